// *** core/trace_cap_pkg.sv ***
// Constants and types for the trace capture front end
package trace_cap_pkg;
  // Packet port width codes
  localparam logic [1:0] PW_4 = 2'h0;
  localparam logic [1:0] PW_8 = 2'h1;
  localparam logic [1:0] PW_16 = 2'h2;
  // Captured word layout: status[2:0], sync[3], packet above
  localparam int STAT_LSB = 0;
  localparam int SYNC_POS = 3;
  localparam int PKT_LSB = 4;
  localparam int SAMPLE_W = 20;
  localparam int BITS_PW4 = 8;
  localparam int BITS_PW8 = 12;
  localparam int BITS_PW16 = 20;
  localparam int TAG_W = 32;
  // Output width codes: bytes per state
  localparam logic [1:0] BPS_1 = 2'h1;
  localparam logic [1:0] BPS_2 = 2'h2;
  localparam logic [1:0] BPS_3 = 2'h3;
  // Notification modes
  localparam logic [1:0] NOTE_OFF = 2'h0;
  localparam logic [1:0] NOTE_TRIG = 2'h1;
  localparam logic [1:0] NOTE_DONE = 2'h2;
  // Chain length limits
  localparam logic [5:0] CHAIN_MAX = 6'h20;
  localparam logic [5:0] CHAIN_DEF = 6'h01;
  // General configuration word
  localparam int GEN_W = 16;
  localparam logic [15:0] GEN_DEF = 16'h0001;
  localparam int CHAIN_LSB = 0;
  // Reset values of trace settings, and FIFO depth
  localparam logic [1:0] PW_DEF = PW_4;
  localparam logic [1:0] BPS_DEF = BPS_2;
  localparam logic [1:0] NOTE_DEF = NOTE_OFF;
  localparam int FIFO_DEPTH = 2;
endpackage

// *** core/trace_port_capture_config.sv ***
// Trace port capture front end with settings and nonvolatile config
// Function
// - 4-bit port stores status, sync, nibble: 8 bits
// - 8-bit port 12 bits, 16-bit 20 bits
// - Output 1, 2 or 3 bytes; default 2
// - Single edge: rising edge only, default
// - Double edge: rising and falling samples
// - Optional time tag relative to trigger
// - Tag taken at sample arrival time
// - Drive off releases run-control lines
// - Trigger mode: event on trigger
// - Complete mode: event on finish or full
// - Notification off: no events
// - Save writes general config, not trace settings
// - Restore reloads last saved config
// - Reinit sets general config and bytes per state to defaults
// - JTAG chain up to 32, default one
`timescale 1ns/10ps
module trace_port_capture_config (
  // System
  input wire logic clk_sys,
  input wire logic arst_n,
  // Trace link
  input wire logic trace_clk,
  input wire logic [2:0] pipeline_status_bits,
  input wire logic trace_sync_flag,
  input wire logic [15:0] trace_packet,
  // Trace settings
  input wire logic [1:0] port_width,
  input wire logic [1:0] bytes_per_state,
  input wire logic double_edge,
  input wire logic time_tag_en,
  input wire logic probe_drive_off,
  input wire logic [1:0] notify_mode,
  input wire logic [1:0] bps_set,
  input wire logic bps_load,
  // Capture control
  input wire logic trigger_in,
  input wire logic capture_done,
  input wire logic buffer_full,
  output logic notify_event,
  // Run-control lines
  input wire logic [1:0] rc_out,
  output logic [1:0] rc_o,
  output logic [1:0] rc_oe,
  // General configuration and storage
  input wire logic [15:0] gen_cfg_wr,
  input wire logic gen_cfg_load,
  input wire logic save_req,
  input wire logic restore_req,
  input wire logic reinit,
  output logic [15:0] gen_cfg,
  output logic [1:0] bps_active,
  output logic [5:0] chain_len,
  output logic [15:0] nv_wdata,
  output logic nv_we,
  input wire logic [15:0] nv_rdata,
  // Captured state stream
  output logic st_valid,
  input wire logic st_ready,
  output logic [23:0] st_data,
  output logic [31:0] st_tag,
  output logic st_tag_valid,
  output logic overrun
);
  // Trace clock domain: rising and falling samples, toggles for events
  logic [19:0] rise_smp_ff, fall_smp_ff;
  logic rise_tgl_ff, fall_tgl_ff;
  logic [1:0] pw_l1_ff, pw_l2_ff;
  logic de_l1_ff, de_l2_ff;
  logic trn_l1_ff, trn_l2_ff;

  function automatic logic [19:0] pack_sample(input logic [1:0] pw, input logic [2:0] st, input logic sy,
                                              input logic [15:0] pk);
    logic [19:0] w;
    w = '0;
    w[trace_cap_pkg::STAT_LSB +: 3] = st;
    w[trace_cap_pkg::SYNC_POS] = sy;
    case (pw)
      trace_cap_pkg::PW_4: w[trace_cap_pkg::PKT_LSB +: 4] = pk[3:0];
      trace_cap_pkg::PW_8: w[trace_cap_pkg::PKT_LSB +: 8] = pk[7:0];
      default: w[trace_cap_pkg::PKT_LSB +: 16] = pk;
    endcase
    return w;
  endfunction

  always_ff @(posedge trace_clk or negedge arst_n) begin
    if (!arst_n) begin
      pw_l1_ff <= '0;
      pw_l2_ff <= '0;
      de_l1_ff <= 1'b0;
      de_l2_ff <= 1'b0;
      rise_smp_ff <= '0;
      rise_tgl_ff <= 1'b0;
    end else begin
      pw_l1_ff <= port_width;
      pw_l2_ff <= pw_l1_ff;
      de_l1_ff <= double_edge;
      de_l2_ff <= de_l1_ff;
      rise_smp_ff <= pack_sample(pw_l2_ff, pipeline_status_bits, trace_sync_flag, trace_packet);
      rise_tgl_ff <= ~rise_tgl_ff;
    end
  end

  always_ff @(negedge trace_clk or negedge arst_n) begin
    if (!arst_n) begin
      trn_l1_ff <= 1'b0;
      trn_l2_ff <= 1'b0;
      fall_smp_ff <= '0;
      fall_tgl_ff <= 1'b0;
    end else begin
      trn_l1_ff <= de_l2_ff;
      trn_l2_ff <= trn_l1_ff;
      if (trn_l2_ff) begin
        fall_smp_ff <= pack_sample(pw_l2_ff, pipeline_status_bits, trace_sync_flag, trace_packet);
        fall_tgl_ff <= ~fall_tgl_ff;
      end
    end
  end

  // System domain state
  typedef struct packed {
    logic [2:0] rt_sync;
    logic [2:0] ft_sync;
    logic [1:0] bps;
    logic [15:0] gen;
    logic [15:0] nv_shadow;
    logic [15:0] nv_wd;
    logic nv_we;
    logic trig_d;
    logic done_d;
    logic trig_seen;
    logic [31:0] tnow;
    logic notify;
    logic [1:0] fvld;
    logic [1:0][23:0] fdat;
    logic [1:0][31:0] ftag;
    logic fwr;
    logic ovr;
    logic [1:0] rc_oe;
  } state_t;
  state_t cur_ff, nxt_cur;

  // Pending samples from a rising and a falling edge in one cycle
  logic rise_new, fall_new;
  logic [23:0] rise_word, fall_word;
  logic push_a, push_b;
  logic [23:0] wa, wb;
  logic [1:0] cnt0, cnt1;

  function automatic logic [23:0] fmt_state(input logic [1:0] bps, input logic [19:0] s);
    case (bps)
      trace_cap_pkg::BPS_1: return {16'h0000, s[7:0]};
      trace_cap_pkg::BPS_3: return {4'h0, s};
      default: return {8'h00, s[15:0]};
    endcase
  endfunction

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.rt_sync = {cur_ff.rt_sync[1:0], rise_tgl_ff};
    nxt_cur.ft_sync = {cur_ff.ft_sync[1:0], fall_tgl_ff};
    rise_new = cur_ff.rt_sync[2] ^ cur_ff.rt_sync[1];
    fall_new = cur_ff.ft_sync[2] ^ cur_ff.ft_sync[1];
    // Samples stable: toggles change on the same trace edge as the data and lag it by the synchronizer
    rise_word = fmt_state(cur_ff.bps, rise_smp_ff);
    fall_word = fmt_state(cur_ff.bps, fall_smp_ff);
    push_a = rise_new | fall_new;
    push_b = rise_new & fall_new;
    wa = rise_new ? rise_word : fall_word;
    wb = fall_word;
    nxt_cur.nv_we = 1'b0;
    // Time base restarts at trigger
    nxt_cur.trig_d = trigger_in;
    nxt_cur.done_d = capture_done | buffer_full;
    nxt_cur.tnow = cur_ff.tnow + 32'h0000_0001;
    if (trigger_in && !cur_ff.trig_d) begin
      nxt_cur.tnow = 32'h0000_0000;
      nxt_cur.trig_seen = 1'b1;
    end
    case (notify_mode)
      trace_cap_pkg::NOTE_TRIG: nxt_cur.notify = trigger_in & ~cur_ff.trig_d;
      trace_cap_pkg::NOTE_DONE: nxt_cur.notify = (capture_done | buffer_full) & ~cur_ff.done_d;
      default: nxt_cur.notify = 1'b0;
    endcase
    nxt_cur.rc_oe = probe_drive_off ? 2'h0 : 2'h3;
    // Two-entry FIFO; entry 0 is the head
    cnt0 = {1'b0, cur_ff.fvld[0]} + {1'b0, cur_ff.fvld[1]};
    if (cur_ff.fvld[0] && st_ready) begin
      nxt_cur.fdat[0] = cur_ff.fdat[1];
      nxt_cur.ftag[0] = cur_ff.ftag[1];
      nxt_cur.fvld = {1'b0, cur_ff.fvld[1]};
      cnt1 = cnt0 - 2'h1;
    end else begin
      cnt1 = cnt0;
    end
    nxt_cur.ovr = 1'b0;
    if (push_a) begin
      if (cnt1 < 2'h2) begin
        nxt_cur.fdat[cnt1[0]] = wa;
        nxt_cur.ftag[cnt1[0]] = cur_ff.tnow;
        nxt_cur.fvld[cnt1[0]] = 1'b1;
        cnt1 = cnt1 + 2'h1;
      end else begin
        nxt_cur.ovr = 1'b1;
      end
    end
    if (push_b) begin
      if (cnt1 < 2'h2) begin
        nxt_cur.fdat[cnt1[0]] = wb;
        nxt_cur.ftag[cnt1[0]] = cur_ff.tnow;
        nxt_cur.fvld[cnt1[0]] = 1'b1;
      end else begin
        nxt_cur.ovr = 1'b1;
      end
    end
    // Configuration: reinit beats restore beats writes
    if (bps_load && bps_set != 2'h0) begin
      nxt_cur.bps = bps_set;
    end
    if (gen_cfg_load) begin
      nxt_cur.gen = gen_cfg_wr;
    end
    if (save_req) begin
      nxt_cur.nv_wd = cur_ff.gen;
      nxt_cur.nv_we = 1'b1;
      nxt_cur.nv_shadow = cur_ff.gen;
    end
    if (restore_req) begin
      nxt_cur.gen = nv_rdata;
    end
    if (nxt_cur.gen[5:0] == 6'h00 || nxt_cur.gen[5:0] > trace_cap_pkg::CHAIN_MAX) begin
      nxt_cur.gen[5:0] = trace_cap_pkg::CHAIN_DEF;
    end
    if (reinit) begin
      nxt_cur.gen = trace_cap_pkg::GEN_DEF;
      nxt_cur.bps = trace_cap_pkg::BPS_DEF;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff <= '0;
      cur_ff.bps <= trace_cap_pkg::BPS_DEF;
      cur_ff.gen <= trace_cap_pkg::GEN_DEF;
      cur_ff.rc_oe <= 2'h3;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign st_valid = cur_ff.fvld[0];
  assign st_data = cur_ff.fdat[0];
  assign st_tag = cur_ff.ftag[0];
  assign st_tag_valid = time_tag_en & cur_ff.trig_seen;
  assign notify_event = cur_ff.notify;
  assign rc_oe = cur_ff.rc_oe;
  assign rc_o = rc_out;
  assign gen_cfg = cur_ff.gen;
  assign bps_active = cur_ff.bps;
  assign chain_len = cur_ff.gen[5:0];
  assign nv_wdata = cur_ff.nv_wd;
  assign nv_we = cur_ff.nv_we;
  assign overrun = cur_ff.ovr;

  // Checks
  sequence trig_rise_s;
    trigger_in && !cur_ff.trig_d;
  endsequence
  trig_note_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (trig_rise_s and notify_mode == trace_cap_pkg::NOTE_TRIG) |=> notify_event)
    else $error("trigger notification missing");
  off_quiet_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $past(notify_mode) == trace_cap_pkg::NOTE_OFF |-> !notify_event)
    else $error("event while notification off");
  done_note_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    notify_mode == trace_cap_pkg::NOTE_DONE && buffer_full && !cur_ff.done_d |=> notify_event)
    else $error("completion notification missing");
  drive_off_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    probe_drive_off |=> rc_oe == 2'h0)
    else $error("run-control still driven");
  reinit_def_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reinit |=> gen_cfg == trace_cap_pkg::GEN_DEF && bps_active == trace_cap_pkg::BPS_DEF)
    else $error("reinit left non-default settings");
  save_nv_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    save_req |=> nv_we && nv_wdata == $past(gen_cfg))
    else $error("save wrote wrong data");
  restore_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    restore_req && !reinit && nv_rdata[5:0] != 6'h00 && nv_rdata[5:0] <= trace_cap_pkg::CHAIN_MAX
    |=> gen_cfg == $past(nv_rdata))
    else $error("restore not applied");
  chain_rng_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    chain_len != 6'h00 && chain_len <= trace_cap_pkg::CHAIN_MAX)
    else $error("chain length out of range");
  hold_data_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    st_valid && !st_ready |=> st_valid && $stable(st_data))
    else $error("stalled state lost");
  width_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    st_valid && bps_active == trace_cap_pkg::BPS_1 && $stable(bps_active) && $rose(st_valid)
    |-> st_data[23:8] == 16'h0000)
    else $error("one-byte state too wide");
endmodule

// *** bench/trace_src.sv ***
// Target trace source model: gated trace clock and counting trace pins
`timescale 1ns/10ps
module trace_src (
  // Control
  input wire logic run,
  // Trace pins
  output logic trace_clk,
  output logic [2:0] pipeline_status_bits,
  output logic trace_sync_flag,
  output logic [15:0] trace_packet
);
  logic [19:0] cnt;
  initial begin
    trace_clk = 1'b0;
    cnt = 20'h00000;
    {trace_packet, trace_sync_flag, pipeline_status_bits} = 20'h00000;
    forever begin
      #12;
      if (run) begin
        cnt = cnt + 20'h00001;
        {trace_packet, trace_sync_flag, pipeline_status_bits} = cnt;
      end else begin
        // Idle pins show no stale value
        {trace_packet, trace_sync_flag, pipeline_status_bits} = ~cnt;
      end
      #12;
      // Clock parks low outside frames
      if (run || trace_clk) begin
        trace_clk = ~trace_clk;
      end
    end
  end
endmodule

// *** bench/testbench.sv ***
// Self-checking bench for the trace capture front end
`timescale 1ns/10ps
module testbench;
  logic clk_sys, arst_n, run, trace_clk, trace_sync_flag, double_edge, time_tag_en, probe_drive_off;
  logic bps_load, trigger_in, capture_done, buffer_full, notify_event, gen_cfg_load, save_req, restore_req;
  logic reinit, nv_we, st_valid, st_ready, st_tag_valid, overrun, seen_we;
  logic [2:0] pipeline_status_bits;
  logic [15:0] trace_packet, gen_cfg_wr, gen_cfg, nv_wdata, nv_rdata;
  logic [1:0] port_width, notify_mode, bps_set, rc_out, rc_o, rc_oe, bps_active;
  logic [5:0] chain_len;
  logic [23:0] st_data;
  logic [31:0] st_tag;
  int n_fail, n_checks, cyc;
  // Selectors for the pulsed and level controls
  localparam int LOAD = 0;
  localparam int SAVE = 1;
  localparam int RESTORE = 2;
  localparam int BPS = 3;
  localparam int INIT = 4;
  localparam int TRIG = 5;
  localparam int DONE = 6;
  localparam int FULL = 7;
  trace_src u_trace_src (.run(run), .trace_clk(trace_clk), .pipeline_status_bits(pipeline_status_bits),
    .trace_sync_flag(trace_sync_flag), .trace_packet(trace_packet));
  trace_port_capture_config u_trace_port_capture_config (.clk_sys(clk_sys), .arst_n(arst_n),
    .trace_clk(trace_clk), .pipeline_status_bits(pipeline_status_bits), .trace_sync_flag(trace_sync_flag),
    .trace_packet(trace_packet), .port_width(port_width), .bytes_per_state(bps_set), .double_edge(double_edge),
    .time_tag_en(time_tag_en), .probe_drive_off(probe_drive_off), .notify_mode(notify_mode),
    .bps_set(bps_set), .bps_load(bps_load), .trigger_in(trigger_in), .capture_done(capture_done),
    .buffer_full(buffer_full), .notify_event(notify_event), .rc_out(rc_out), .rc_o(rc_o), .rc_oe(rc_oe),
    .gen_cfg_wr(gen_cfg_wr), .gen_cfg_load(gen_cfg_load), .save_req(save_req), .restore_req(restore_req),
    .reinit(reinit), .gen_cfg(gen_cfg), .bps_active(bps_active), .chain_len(chain_len),
    .nv_wdata(nv_wdata), .nv_we(nv_we), .nv_rdata(nv_rdata), .st_valid(st_valid), .st_ready(st_ready),
    .st_data(st_data), .st_tag(st_tag), .st_tag_valid(st_tag_valid), .overrun(overrun));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Nonvolatile store stand-in
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      final_report();
    end
    if (nv_we === 1'b1) begin
      seen_we <= 1'b1;
      nv_rdata <= nv_wdata;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // Drive one control, always by non-blocking assignment
  task automatic drive(input int w, input logic v);
    case (w)
      LOAD: gen_cfg_load <= v;
      SAVE: save_req <= v;
      RESTORE: restore_req <= v;
      BPS: bps_load <= v;
      INIT: reinit <= v;
      TRIG: trigger_in <= v;
      DONE: capture_done <= v;
      default: buffer_full <= v;
    endcase
  endtask
  // One-cycle pulse; returns on a rising edge once outputs have settled
  task automatic pulse(input int w);
    @(posedge clk_sys);
    drive(w, 1'b1);
    @(posedge clk_sys);
    drive(w, 1'b0);
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic note(input logic [1:0] md, input int w, input logic hit);
    int n;
    n = 0;
    @(posedge clk_sys);
    notify_mode <= md;
    drive(w, 1'b1);
    repeat (4) begin
      @(negedge clk_sys);
      n += (notify_event === 1'b1);
    end
    @(posedge clk_sys);
    drive(w, 1'b0);
    repeat (4) @(posedge clk_sys);
    chk("events", hit, n);
  endtask
  task automatic cfg();
    chk("gen_rst", 16'h0001, gen_cfg);
    chk("chain_rst", 6'h01, chain_len);
    chk("bps_rst", 2'h2, bps_active);
    chk("rc_oe_rst", 2'h3, rc_oe);
    gen_cfg_wr <= 16'h0020;
    pulse(LOAD);
    chk("chain32", 6'h20, chain_len);
    pulse(SAVE);
    chk("saved", 16'h0020, {15'h0000, seen_we} << 5 & nv_rdata);
    gen_cfg_wr <= 16'h0021;
    pulse(LOAD);
    chk("chain_ovr", 6'h01, chain_len);
    pulse(RESTORE);
    chk("restored", 16'h0020, gen_cfg);
    bps_set <= 2'h3;
    pulse(BPS);
    chk("bps3", 2'h3, bps_active);
    bps_set <= 2'h0;
    pulse(BPS);
    chk("bps0", 2'h3, bps_active);
    pulse(INIT);
    chk("gen_def", 16'h0001, gen_cfg);
    chk("bps_def", 2'h2, bps_active);
    rc_out <= 2'h2;
    probe_drive_off <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("rc_off", 2'h0, rc_oe);
    chk("rc_o", 2'h2, rc_o);
    probe_drive_off <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("rc_on", 2'h3, rc_oe);
  endtask
  task automatic stream(input logic [1:0] pw, input logic dbl, input logic [1:0] bps);
    logic [23:0] m, prev;
    logic [31:0] pt;
    int k, nb;
    k = 0;
    nb = (pw == 2'h0) ? 8 : (pw == 2'h1) ? 12 : 20;
    nb = (8 * bps < nb) ? 8 * bps : nb;
    m = (24'h000001 << nb) - 24'h000001;
    @(posedge clk_sys);
    port_width <= pw;
    double_edge <= dbl;
    bps_set <= bps;
    pulse(BPS);
    run <= 1'b1;
    for (int c = 0; c < 600 && k < 14; c++) begin
      @(negedge clk_sys);
      if (st_valid === 1'b1) begin
        if (k > 7) begin
          chk("word", (prev + (dbl ? 24'h000001 : 24'h000002)) & m, st_data);
          chk("tag_up", 1, st_tag > pt);
        end
        prev = st_data;
        pt = st_tag;
        k++;
      end
    end
    chk("count", 14, k);
    @(posedge clk_sys);
    run <= 1'b0;
    repeat (40) @(posedge clk_sys);
  endtask
  task automatic stall();
    logic seen;
    seen = 1'b0;
    st_ready <= 1'b0;
    run <= 1'b1;
    repeat (60) begin
      @(negedge clk_sys);
      seen |= (overrun === 1'b1);
    end
    chk("overrun", 1, seen);
    chk("held", 1, st_valid);
    @(posedge clk_sys);
    run <= 1'b0;
    st_ready <= 1'b1;
    repeat (40) @(posedge clk_sys);
  endtask
  task automatic final_report();
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    {arst_n, run, double_edge, time_tag_en, probe_drive_off, bps_load, trigger_in, capture_done} = 8'h00;
    {buffer_full, gen_cfg_load, save_req, restore_req, reinit, seen_we, st_ready} = 7'h01;
    {port_width, notify_mode, bps_set, rc_out} = 8'h00;
    {gen_cfg_wr, nv_rdata} = 32'h00000000;
    {n_fail, n_checks, cyc} = 0;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    cfg();
    note(trace_cap_pkg::NOTE_TRIG, TRIG, 1);
    note(trace_cap_pkg::NOTE_TRIG, DONE, 0);
    note(trace_cap_pkg::NOTE_DONE, DONE, 1);
    note(trace_cap_pkg::NOTE_DONE, FULL, 1);
    note(trace_cap_pkg::NOTE_OFF, TRIG, 0);
    note(trace_cap_pkg::NOTE_OFF, FULL, 0);
    chk("tag_off", 0, st_tag_valid);
    time_tag_en <= 1'b1;
    note(trace_cap_pkg::NOTE_OFF, TRIG, 0);
    chk("tag_on", 1, st_tag_valid);
    stream(trace_cap_pkg::PW_4, 1'b0, trace_cap_pkg::BPS_3);
    stream(trace_cap_pkg::PW_8, 1'b1, trace_cap_pkg::BPS_3);
    stream(trace_cap_pkg::PW_16, 1'b0, trace_cap_pkg::BPS_3);
    stream(trace_cap_pkg::PW_16, 1'b1, trace_cap_pkg::BPS_1);
    stream(trace_cap_pkg::PW_16, 1'b0, trace_cap_pkg::BPS_2);
    stall();
    final_report();
  end
endmodule
